//--- rtl/hsarb_pkg.sv
// Shared constants and types of the hardware semaphore arbiter.
// Assumes one clock domain; every requester is synchronous logic on it.
package hsarb_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NCORE = 3;
    localparam int NSEM = 32;
    localparam int SEM_W = 5;
    localparam int CORE_W = 2;
    localparam logic [1:0] QDEPTH = 2'h2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [1:0] RR_RST = 2'h0;
    localparam logic [31:0] FLAG_RST = 32'h0000_0000;
    localparam logic [1:0] QCNT_RST = 2'h0;

    // ------------------------------------------------------------
    // Claim modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HSARB_DIRECT,
        HSARB_INDIRECT,
        HSARB_COMBINED
    } hsarb_mode_t;

endpackage

//--- rtl/hsarb_sem_cell.sv
// One semaphore: owner, owned bit and a two-entry pending queue.
// Assumes the parent presents at most one access per cycle to all cells.
module hsarb_sem_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Access presented this cycle
    input wire logic acc_hit,
    input wire logic acc_rel,
    input wire hsarb_pkg::hsarb_mode_t acc_mode,
    input wire logic [1:0] acc_core,
    // Outcome of the access
    output logic grant,
    output logic notify,
    output logic [1:0] notify_core
);

    // Queue depth at the width of the counter it is compared with
    localparam logic [1:0] QDEPTH_L = hsarb_pkg::QDEPTH;

    logic owned_r, owned_nxt;
    logic [1:0] owner_r, owner_nxt;
    logic [1:0] qcnt_r, qcnt_nxt;
    logic [1:0] q0_r, q0_nxt;
    logic [1:0] q1_r, q1_nxt;
    logic queued;
    logic owner_rel;

    // ------------------------------------------------------------
    // Next state, decided in one cycle so the update is indivisible
    // ------------------------------------------------------------
    assign owner_rel = acc_hit && acc_rel && owned_r && (owner_r == acc_core);

    // Claim and release decode
    always_comb begin
        owned_nxt = owned_r;
        owner_nxt = owner_r;
        qcnt_nxt = qcnt_r;
        q0_nxt = q0_r;
        q1_nxt = q1_r;
        grant = 1'b0;
        notify = 1'b0;
        notify_core = acc_core;
        queued = (qcnt_r != 2'h0 && q0_r == acc_core) || (qcnt_r == QDEPTH_L && q1_r == acc_core);
        if (owner_rel) begin
            if (qcnt_r != 2'h0) begin
                owner_nxt = q0_r;
                q0_nxt = q1_r;
                qcnt_nxt = qcnt_r - 2'h1;
                notify = 1'b1;
                notify_core = q0_r;
            end else begin
                owned_nxt = 1'b0;
            end
        end else if (acc_hit && !acc_rel) begin
            if (!owned_r) begin
                // Free: every mode takes it at once
                owned_nxt = 1'b1;
                owner_nxt = acc_core;
                grant = 1'b1;
                notify = (acc_mode == hsarb_pkg::HSARB_INDIRECT);
            end else if (owner_r == acc_core) begin
                grant = 1'b1; // Owner asking again keeps it
            end else if (acc_mode != hsarb_pkg::HSARB_DIRECT && !queued && qcnt_r < QDEPTH_L) begin
                // Held by another core: queue, never withdrawn later
                if (qcnt_r == 2'h0) begin
                    q0_nxt = acc_core;
                end else begin
                    q1_nxt = acc_core;
                end
                qcnt_nxt = qcnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Ownership and queue; a release by a non-owner falls through untouched
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            owned_r <= 1'b0;
            owner_r <= 2'h0;
            qcnt_r <= hsarb_pkg::QCNT_RST;
            q0_r <= 2'h0;
            q1_r <= 2'h0;
        end else begin
            owned_r <= owned_nxt;
            owner_r <= owner_nxt;
            qcnt_r <= qcnt_nxt;
            q0_r <= q0_nxt;
            q1_r <= q1_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_direct_held;
        @(posedge clk) disable iff (sys_rst)
        acc_hit && !acc_rel && acc_mode == hsarb_pkg::HSARB_DIRECT && owned_r
        |=> $stable(owner_r) && $stable(qcnt_r) && owned_r;
    endproperty
    a_direct_held: assert property (p_direct_held) else $error("direct claim on held semaphore changed state");

    property p_free_grant;
        @(posedge clk) disable iff (sys_rst)
        acc_hit && !acc_rel && !owned_r |-> grant ##1 (owned_r && owner_r == $past(acc_core));
    endproperty
    a_free_grant: assert property (p_free_grant) else $error("free semaphore not granted");

    property p_comb_queue;
        @(posedge clk) disable iff (sys_rst)
        acc_hit && !acc_rel && acc_mode == hsarb_pkg::HSARB_COMBINED && owned_r && owner_r != acc_core
        && qcnt_r == 2'h0 |-> !grant ##1 (qcnt_r == 2'h1 && q0_r == $past(acc_core));
    endproperty
    a_comb_queue: assert property (p_comb_queue) else $error("combined claim not queued");

    property p_handoff;
        @(posedge clk) disable iff (sys_rst)
        owner_rel && qcnt_r != 2'h0 |=> owned_r && owner_r == $past(q0_r);
    endproperty
    a_handoff: assert property (p_handoff) else $error("release did not pass to oldest waiter");

    property p_foreign_release;
        @(posedge clk) disable iff (sys_rst)
        acc_hit && acc_rel && !(owned_r && owner_r == acc_core)
        |=> $stable(owned_r) && $stable(owner_r) && $stable(qcnt_r);
    endproperty
    a_foreign_release: assert property (p_foreign_release) else $error("non-owner release changed state");

    property p_no_withdraw;
        @(posedge clk) disable iff (sys_rst)
        !owner_rel |=> qcnt_r >= $past(qcnt_r);
    endproperty
    a_no_withdraw: assert property (p_no_withdraw) else $error("queued request vanished");

    property p_depth;
        @(posedge clk) disable iff (sys_rst)
        qcnt_r <= hsarb_pkg::QDEPTH && (qcnt_r == 2'h0 || owned_r);
    endproperty
    a_depth: assert property (p_depth) else $error("queue over depth or waiting on a free semaphore");

endmodule

//--- rtl/hsarb_top.sv
// Hardware semaphore arbiter for three cores sharing 32 semaphores.
// Assumes each core drives a level request held until its response pulse.
// Assumes flag clears come as one-cycle pulses; a held clear clears each cycle.
//
// Function
// - Claims are atomic read-modify-write, never interleaved.
// - Thirty-two independent semaphores, no fixed resource.
// - Direct, indirect and combined claim modes.
// - Direct: grant if free, else nothing.
// - Indirect: record, interrupt requester when available.
// - One owner plus two-deep pending queue.
// - Queued requests cannot be withdrawn.
// - Availability sets flag, interrupts originating core only.
// - Combined on free semaphore grants immediately.
// - Combined on held semaphore denies and queues.
module hsarb_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Access requests, one lane per core
    input wire logic [2:0] core_req,
    input wire logic [2:0] core_rel,
    input wire hsarb_pkg::hsarb_mode_t core_mode [3],
    input wire logic [2:0][4:0] core_sem,
    // Availability flag clears, one lane per core
    input wire logic [2:0] flag_clr,
    input wire logic [2:0][4:0] flag_clr_sem,
    // Access responses
    output logic [2:0] rsp_valid,
    output logic [2:0] rsp_grant,
    // Availability flags and interrupts
    output logic [2:0][31:0] sem_grant_flag,
    output logic [2:0] sem_irq
);

    logic [1:0] rr_r;
    logic sel_valid;
    logic [1:0] sel_core;
    logic [2:0] take;
    logic acc_rel;
    hsarb_pkg::hsarb_mode_t acc_mode;
    logic [4:0] acc_sem;
    logic [31:0] grant_v;
    logic [31:0] notify_v;
    logic [31:0][1:0] notify_core_v;
    logic grant_any;
    logic [2:0][31:0] flag_set;
    logic [2:0][31:0] flag_clr_mask;

    // ------------------------------------------------------------
    // Access selection
    // ------------------------------------------------------------
    // Round robin over cores with a request and no response in flight.
    // Only one access reaches the semaphores per cycle, which is what
    // makes each claim indivisible without any locking protocol.
    always_comb begin
        int idx;
        idx = 0;
        sel_valid = 1'b0;
        sel_core = rr_r;
        take = 3'h0;
        for (int k = 1; k <= hsarb_pkg::NCORE; k++) begin
            idx = (int'(rr_r) + k) % hsarb_pkg::NCORE;
            if (!sel_valid && core_req[idx] && !rsp_valid[idx]) begin
                sel_valid = 1'b1;
                sel_core = 2'(idx);
            end
        end
        if (sel_valid) begin
            take[sel_core] = 1'b1;
        end
    end

    // Selected access fields
    assign acc_rel = core_rel[sel_core];
    assign acc_mode = core_mode[sel_core];
    assign acc_sem = core_sem[sel_core];

    // Fairness pointer moves to the last winner
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rr_r <= hsarb_pkg::RR_RST;
        end else if (sel_valid) begin
            rr_r <= sel_core;
        end
    end

    // ------------------------------------------------------------
    // Semaphore array
    // ------------------------------------------------------------
    // Each cell only sees the access addressed to it
    for (genvar s = 0; s < hsarb_pkg::NSEM; s++) begin : g_sem
        hsarb_sem_cell u_cell (
            .clk(clk),
            .sys_rst(sys_rst),
            .acc_hit(sel_valid && acc_sem == 5'(s)),
            .acc_rel(acc_rel),
            .acc_mode(acc_mode),
            .acc_core(sel_core),
            .grant(grant_v[s]),
            .notify(notify_v[s]),
            .notify_core(notify_core_v[s])
        );
    end

    assign grant_any = |grant_v;

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    // One-cycle pulse on the lane that was served, with the claim result
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 3'h0;
            rsp_grant <= 3'h0;
        end else begin
            rsp_valid <= take;
            rsp_grant <= take & {3{grant_any && !acc_rel}};
        end
    end

    // ------------------------------------------------------------
    // Availability flags and interrupts
    // ------------------------------------------------------------
    for (genvar c = 0; c < hsarb_pkg::NCORE; c++) begin : g_core
        for (genvar s = 0; s < hsarb_pkg::NSEM; s++) begin : g_bit
            // Only the core named by the cell sees the event
            assign flag_set[c][s] = notify_v[s] && notify_core_v[s] == 2'(c);
        end

        assign flag_clr_mask[c] = flag_clr[c] ? (32'h0000_0001 << flag_clr_sem[c]) : 32'h0000_0000;

        // Set wins over a clear in the same cycle so no grant is lost
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                sem_grant_flag[c] <= hsarb_pkg::FLAG_RST;
                sem_irq[c] <= 1'b0;
            end else begin
                sem_grant_flag[c] <= (sem_grant_flag[c] & ~flag_clr_mask[c]) | flag_set[c];
                sem_irq[c] <= |flag_set[c];
            end
        end

        // --------------------------------------------------------
        // Per-core checks
        // --------------------------------------------------------
        property p_rsp;
            @(posedge clk) disable iff (sys_rst)
            take[c] |=> rsp_valid[c] && rsp_grant[c] == $past(grant_any && !acc_rel) ##1 !rsp_valid[c];
        endproperty
        a_rsp: assert property (p_rsp) else $error("claim response missing or wrong");

        property p_flag_irq;
            @(posedge clk) disable iff (sys_rst)
            |flag_set[c] |=> sem_irq[c] && (sem_grant_flag[c] & $past(flag_set[c])) == $past(flag_set[c]);
        endproperty
        a_flag_irq: assert property (p_flag_irq) else $error("availability not flagged to its core");

        property p_irq_cause;
            @(posedge clk) disable iff (sys_rst)
            sem_irq[c] |-> $past(notify_v) != 32'h0000_0000;
        endproperty
        a_irq_cause: assert property (p_irq_cause) else $error("interrupt without availability event");

        // A release is never reported as a grant
        property p_rel_no_grant;
            @(posedge clk) disable iff (sys_rst)
            take[c] && acc_rel |=> rsp_valid[c] && !rsp_grant[c];
        endproperty
        a_rel_no_grant: assert property (p_rel_no_grant) else $error("release reported as grant");

        // A response only follows an access taken for this core
        property p_rsp_cause;
            @(posedge clk) disable iff (sys_rst)
            rsp_valid[c] |-> $past(take[c]);
        endproperty
        a_rsp_cause: assert property (p_rsp_cause) else $error("response without a taken access");

        // Round robin bounds the wait of a held request to two other accesses
        property p_wait_bound;
            @(posedge clk) disable iff (sys_rst)
            core_req[c] && !rsp_valid[c] |-> ##[0:2] take[c];
        endproperty
        a_wait_bound: assert property (p_wait_bound) else $error("held request starved");

        // Flags fall only by an explicit clear, so a grant is never lost
        property p_flag_hold;
            @(posedge clk) disable iff (sys_rst)
            ($past(sem_grant_flag[c]) & ~$past(flag_clr_mask[c]) & ~sem_grant_flag[c]) == 32'h0000_0000;
        endproperty
        a_flag_hold: assert property (p_flag_hold) else $error("availability flag lost without a clear");

        // A clear with no set on the same flag drops it
        property p_flag_clear;
            @(posedge clk) disable iff (sys_rst)
            flag_clr[c] && !flag_set[c][flag_clr_sem[c]] |=> !sem_grant_flag[c][$past(flag_clr_sem[c])];
        endproperty
        a_flag_clear: assert property (p_flag_clear) else $error("availability flag not cleared");
    end

    // ------------------------------------------------------------
    // Global checks
    // ------------------------------------------------------------
    property p_one_access;
        @(posedge clk) disable iff (sys_rst)
        $onehot0(take) && $onehot0(notify_v) && (sel_valid || notify_v == 32'h0000_0000);
    endproperty
    a_one_access: assert property (p_one_access) else $error("more than one access in a cycle");

    // The fairness pointer follows the last winner
    property p_rr_follow;
        @(posedge clk) disable iff (sys_rst)
        sel_valid |=> rr_r == $past(sel_core);
    endproperty
    a_rr_follow: assert property (p_rr_follow) else $error("fairness pointer not at last winner");

endmodule

//--- bench/hsarb_core_model.sv
// Behavioural model of one requesting core on an arbiter access lane.
// Assumes the arbiter answers with a one-cycle rsp_valid pulse per access.
module hsarb_core_model (
    // Clock and response lane
    input wire logic clk,
    input wire logic rsp_valid,
    input wire logic rsp_grant,
    // Request lane toward the arbiter
    output logic req,
    output logic rel,
    output hsarb_pkg::hsarb_mode_t mode,
    output logic [4:0] sem
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle lane after time zero
    initial begin
        req = 1'b0;
        rel = 1'b0;
        mode = hsarb_pkg::HSARB_DIRECT;
        sem = 5'h00;
    end

    // One access after d + 1 idle cycles; the request holds until the edge after the pulse is seen
    task automatic access(input int d, input logic r, input hsarb_pkg::hsarb_mode_t m, input logic [4:0] s,
                          output logic g, output logic ok);
        int n;
        repeat (d) @(posedge clk);
        @(posedge clk);
        #1;
        req = 1'b1;
        rel = r;
        mode = m;
        sem = s;
        g = 1'b0;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1) begin
                ok = 1'b1;
                g = rsp_grant;
            end
        end
        // Released lanes show the inverse rel and sem, mode keeping its value, so stale values cannot pass for a request
        @(posedge clk);
        #1;
        req = 1'b0;
        rel = ~r;
        sem = ~s;
    endtask
endmodule

//--- bench/hsarb_top_test.sv
// Self-checking bench of the semaphore arbiter with three core models.
// Assumes the design files and package are compiled first.
module hsarb_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam hsarb_pkg::hsarb_mode_t DIR = hsarb_pkg::HSARB_DIRECT;
    localparam hsarb_pkg::hsarb_mode_t IND = hsarb_pkg::HSARB_INDIRECT;
    localparam hsarb_pkg::hsarb_mode_t CMB = hsarb_pkg::HSARB_COMBINED;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] flag_clr = 3'h0;
    logic [2:0][4:0] flag_clr_sem = '0;
    wire logic [2:0] req;
    wire logic [2:0] rel;
    wire hsarb_pkg::hsarb_mode_t mode [3];
    wire logic [2:0][4:0] sem;
    logic [2:0] rsp_valid;
    logic [2:0] rsp_grant;
    logic [2:0] sem_irq;
    logic [2:0][31:0] sem_grant_flag;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    int irq_cnt [3] = '{0, 0, 0};

    hsarb_top dut (.clk(clk), .sys_rst(sys_rst), .core_req(req), .core_rel(rel), .core_mode(mode),
        .core_sem(sem), .flag_clr(flag_clr), .flag_clr_sem(flag_clr_sem), .rsp_valid(rsp_valid),
        .rsp_grant(rsp_grant), .sem_grant_flag(sem_grant_flag), .sem_irq(sem_irq));

    // One core model per lane
    for (genvar c = 0; c < 3; c++) begin : g_core
        hsarb_core_model core (.clk(clk), .rsp_valid(rsp_valid[c]), .rsp_grant(rsp_grant[c]), .req(req[c]),
            .rel(rel[c]), .mode(mode[c]), .sem(sem[c]));
    end

    // Clock, interrupt pulse counting and hang limit
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        for (int c = 0; c < 3; c++) if (sem_irq[c] === 1'b1) irq_cnt[c]++;
        if (cycles > 3000) begin
            fails++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Compare and access helpers
    // ------------------------------------------------------------
    task automatic chk(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_flags(input int c, input logic [31:0] exp);
        chk(sem_grant_flag[c] === exp, 1'b1, "availability flags");
    endtask
    task automatic chk_irq(input int a, input int b, input int d);
        chk(irq_cnt[0] == a && irq_cnt[1] == b && irq_cnt[2] == d, 1'b1, "interrupt pulse counts");
    endtask
    // Access by core c; a missing response counts as a mismatch
    task automatic acc(input int c, input logic r, input hsarb_pkg::hsarb_mode_t m, input logic [4:0] s,
                       output logic g);
        logic ok;
        case (c)
            0: g_core[0].core.access(0, r, m, s, g, ok);
            1: g_core[1].core.access(1, r, m, s, g, ok);
            default: g_core[2].core.access(0, r, m, s, g, ok);
        endcase
        chk(ok, 1'b1, "no response");
    endtask
    task automatic acx(input int c, input logic r, input hsarb_pkg::hsarb_mode_t m, input logic [4:0] s,
                       input logic exp);
        logic g;
        acc(c, r, m, s, g);
        chk(g, exp, "grant result");
    endtask

    // ------------------------------------------------------------
    // Scenarios; semaphore numbers follow one mapping for all cores
    // ------------------------------------------------------------
    task automatic t_direct();
        chk(rsp_valid === 3'h0 && sem_irq === 3'h0, 1'b1, "idle after reset");
        chk_flags(0, 32'h0000_0000);
        acx(1, 1'b0, DIR, 5'h00, 1'b1);
        acx(2, 1'b0, DIR, 5'h00, 1'b0);
        acx(2, 1'b1, DIR, 5'h00, 1'b0);
        acx(2, 1'b0, DIR, 5'h00, 1'b0);
        acx(2, 1'b0, DIR, 5'h1F, 1'b1);
        chk_flags(2, 32'h0000_0000);
        acx(1, 1'b1, DIR, 5'h00, 1'b0);
        acx(2, 1'b1, DIR, 5'h1F, 1'b0);
        acx(0, 1'b0, DIR, 5'h00, 1'b1);
        acx(0, 1'b1, DIR, 5'h00, 1'b0);
        chk_irq(0, 0, 0);
        $display("test direct done");
    endtask

    task automatic t_queue();
        acx(0, 1'b0, CMB, 5'h05, 1'b1);
        acx(1, 1'b0, CMB, 5'h05, 1'b0);
        acx(2, 1'b0, IND, 5'h05, 1'b0);
        acx(0, 1'b1, DIR, 5'h05, 1'b0);
        chk_flags(1, 32'h0000_0020);
        chk_irq(0, 1, 0);
        acx(0, 1'b0, DIR, 5'h05, 1'b0);
        acx(1, 1'b1, DIR, 5'h05, 1'b0);
        chk_flags(2, 32'h0000_0020);
        chk_irq(0, 1, 1);
        acx(2, 1'b1, DIR, 5'h05, 1'b0);
        acx(0, 1'b0, DIR, 5'h05, 1'b1);
        acx(0, 1'b1, DIR, 5'h05, 1'b0);
        acx(1, 1'b0, IND, 5'h07, 1'b1);
        chk_flags(1, 32'h0000_00A0);
        // Clearing a flag is informational only
        @(posedge clk);
        #1;
        flag_clr = 3'h2;
        flag_clr_sem[1] = 5'h05;
        @(posedge clk);
        #1;
        flag_clr = 3'h0;
        @(posedge clk);
        #1;
        chk_flags(1, 32'h0000_0080);
        acx(1, 1'b1, DIR, 5'h07, 1'b0);
        chk_irq(0, 2, 1);
        $display("test queue done");
    endtask

    task automatic t_atomic();
        logic g [3];
        fork
            acc(0, 1'b0, DIR, 5'h09, g[0]);
            acc(1, 1'b0, DIR, 5'h09, g[1]);
            acc(2, 1'b0, DIR, 5'h09, g[2]);
        join
        chk({g[0], g[1], g[2]} inside {3'h1, 3'h2, 3'h4}, 1'b1, "exactly one owner");
        for (int c = 0; c < 3; c++) if (g[c] === 1'b1) acx(c, 1'b1, DIR, 5'h09, 1'b0);
        $display("test atomic done");
    endtask

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_direct();
        t_queue();
        t_atomic();
        print_verdict();
    end
endmodule
